// ### design/adc_seq_pkg.sv
package adc_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int RES_W       = 12;
  localparam int FRAME_W     = 16;
  localparam int FIFO_DEPTH  = 8;
  localparam int FIFO_CNT_W  = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame geometry
  localparam logic [4:0] CMD_BITS   = 5'h04;
  localparam logic [4:0] FRAME_BITS = 5'h10;

  // Command nibbles; 0x0..0x7 select a channel
  localparam logic [3:0] CMD_SW_PD   = 4'h8;
  localparam logic [3:0] CMD_RD_CFG  = 4'h9;
  localparam logic [3:0] CMD_WR_CFG  = 4'hA;
  localparam logic [3:0] CMD_RD_FIFO = 4'hE;
  localparam logic [15:0] SW_PD_WORD = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration register layout and reset value
  localparam logic [11:0] CFG_RESET      = 12'h000;
  localparam int          CFG_REF_INT    = 11;
  localparam int          CFG_EXT_SAMP   = 10;
  localparam int          CFG_SWEEP_LSB  = 8;
  localparam int          CFG_EOC_SEL    = 7;
  localparam int          CFG_MODE_LSB   = 5;
  localparam int          CFG_CLKSRC_LSB = 3;
  localparam int          CFG_DEPTH_LSB  = 0;

  // Conversion clock source codes
  localparam logic [1:0] CLK_INTERNAL = 2'h0;
  localparam logic [1:0] CLK_SCLK_DIV1 = 2'h1;
  localparam logic [1:0] CLK_SCLK_DIV2 = 2'h2;

  // Thresholds for depth codes 00..11 (full, 3/4, 1/2, 1/4), single shot
  localparam logic [3:0] THR_D0     = 4'h8;
  localparam logic [3:0] THR_D1     = 4'h6;
  localparam logic [3:0] THR_D2     = 4'h4;
  localparam logic [3:0] THR_D3     = 4'h2;
  localparam logic [3:0] THR_SINGLE = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam logic [3:0] CONV_CLKS    = 4'hE;
  localparam int         CLK_PERIOD_NS = 4;
  localparam int         EOC_PULSE_NS  = 100;
  localparam int         EOC_PULSE_CYC = (EOC_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] LOAD_DELAY    = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {MODE_SINGLE, MODE_REPEAT, MODE_SWEEP, MODE_RPT_SWEEP} mode_type;
  typedef enum logic [1:0] {CV_IDLE, CV_ARMED, CV_RUN} conv_state_type;

endpackage

// ### design/fifo_if.sv
`timescale 1ns/10ps
interface fifo_if #(
  parameter int WIDTH = 12,
  parameter int CNT_W = 4
);
  logic             push;
  logic [WIDTH-1:0] push_data;
  logic             pop;
  logic             clear;
  logic [WIDTH-1:0] head_data;
  logic [CNT_W-1:0] count;

  modport owner (output push, push_data, pop, clear, input head_data, count);
  modport store (input push, push_data, pop, clear, output head_data, count);
endinterface

// ### design/fifo_store.sv
`timescale 1ns/10ps
module fifo_store #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  input  wire logic sys_clk,
  input  wire logic nrst,
  fifo_if.store     f
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [CNT_W-1:0] count_r;
  logic [WIDTH-1:0] head_r;
  logic             do_push;
  logic             do_pop;

  // Full and empty guard the pointers; clear wins over both
  assign do_push = f.push & (count_r != CNT_W'(DEPTH));
  assign do_pop  = f.pop & (count_r != '0);

  // Pointers and occupancy
  always_ff @(posedge sys_clk) begin
    if (!nrst || f.clear) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (do_push) wr_ptr_r <= wr_ptr_r + 1'b1;
      if (do_pop) rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  // Storage, no reset needed on data
  always_ff @(posedge sys_clk) begin
    if (do_push && !f.clear) mem_r[wr_ptr_r] <= f.push_data;
  end

  // Registered oldest entry, one cycle behind the read pointer
  always_ff @(posedge sys_clk) begin
    head_r <= mem_r[rd_ptr_r];
  end

  assign f.head_data = head_r;
  assign f.count     = count_r;
endmodule

// ### design/adc_serial_fifo_sequencer.sv
`timescale 1ns/10ps
module adc_serial_fifo_sequencer (
  input  wire logic                           sys_clk,
  input  wire logic                           nrst,
  input  wire logic                           sclk_in,
  input  wire logic                           cs_n_in,
  input  wire logic                           frame_sync_in,
  input  wire logic                           sdi_in,
  input  wire logic                           sample_trigger_in_n,
  input  wire logic                           pwdn_n_in,
  input  wire logic                           onchip_timebase,
  input  wire logic [adc_seq_pkg::RES_W-1:0]  result_in,
  output logic                                sdo_out,
  output logic                                sdo_oe,
  output logic                                eoc_int_n_out,
  output logic                                conv_start_out,
  output logic [2:0]                          conv_chan_out,
  output logic                                auto_pd_out,
  output logic                                power_down_out,
  output logic [adc_seq_pkg::RES_W-1:0]       config_out
);
  import adc_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic        sclk_q_r, cs_n_q_r, fs_q_r, trig_n_q_r, tb_q_r;
  logic        sclk_rise, sclk_fall, cs_act, cs_fall, fs_rise;
  logic        trig_fall, trig_rise, tb_rise;
  logic [11:0] config_register_r;
  mode_type    mode;
  logic        fifo_mode, ref_int, ext_samp, eoc_sel;
  logic [1:0]  sweep_sel, clk_src, depth_sel;
  logic [3:0]  threshold;
  logic [4:0]  bit_cnt_r;
  logic [15:0] shift_in_r, shift_out_r, word_now;
  logic [3:0]  cmd_r, cmd_now;
  logic        rise_in_frame, frame_start, at_decode, at_end;
  logic        sdo_r, sdo_oe_r, next_rd;
  logic [1:0]  load_dly_r;
  logic        load_now, sel_end, pop_now;
  logic        thr_hit, thr_hit_q_r, after_int_r, clear_pend_r;
  logic        clear_set, fifo_clear;
  conv_state_type state_r;
  logic [3:0]  tick_cnt_r;
  logic [1:0]  div_cnt_r, div_last;
  logic        conv_tick, conv_done, start_pend_r, start_set, start_go;
  logic [2:0]  sel_chan_r, sweep_idx_r, sweep_last, start_chan, conv_chan_r;
  logic        conv_start_r;
  logic [11:0] buf0_r, buf1_r;
  logic [1:0]  buf_cnt_r;
  logic        buf_push, buf_pop, buf_wsel, buf_room;
  logic [5:0]  eoc_cnt_r;
  logic        eoc_int_n_r, auto_pd_r, sw_pd_r, pd_any, pd_q_r, pd_enter;

  fifo_if #(.WIDTH(RES_W), .CNT_W(FIFO_CNT_W)) fq ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin edge tracking; pins are already synchronous to sys_clk
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sclk_q_r   <= 1'b0;
      cs_n_q_r   <= 1'b1;
      fs_q_r     <= 1'b0;
      trig_n_q_r <= 1'b1;
      tb_q_r     <= 1'b0;
    end else begin
      sclk_q_r   <= sclk_in;
      cs_n_q_r   <= cs_n_in;
      fs_q_r     <= frame_sync_in;
      trig_n_q_r <= sample_trigger_in_n;
      tb_q_r     <= onchip_timebase;
    end
  end

  // Edge decode
  assign sclk_rise = sclk_in & ~sclk_q_r;
  assign sclk_fall = ~sclk_in & sclk_q_r;
  assign cs_act    = ~cs_n_in;
  assign cs_fall   = cs_n_q_r & ~cs_n_in;
  assign fs_rise   = frame_sync_in & ~fs_q_r;
  assign trig_fall = trig_n_q_r & ~sample_trigger_in_n;
  assign trig_rise = ~trig_n_q_r & sample_trigger_in_n;
  assign tb_rise   = onchip_timebase & ~tb_q_r;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration fields
  assign mode      = mode_type'(config_register_r[CFG_MODE_LSB +: 2]);
  assign fifo_mode = (mode != MODE_SINGLE);
  assign ref_int   = config_register_r[CFG_REF_INT];
  assign ext_samp  = config_register_r[CFG_EXT_SAMP];
  assign eoc_sel   = config_register_r[CFG_EOC_SEL];
  assign sweep_sel = config_register_r[CFG_SWEEP_LSB +: 2];
  assign clk_src   = config_register_r[CFG_CLKSRC_LSB +: 2];
  assign depth_sel = config_register_r[CFG_DEPTH_LSB +: 2];

  // Threshold; single shot overrides the depth bits
  assign threshold = (mode == MODE_SINGLE) ? THR_SINGLE :
                     (depth_sel == 2'h0)   ? THR_D0 :
                     (depth_sel == 2'h1)   ? THR_D1 :
                     (depth_sel == 2'h2)   ? THR_D2 : THR_D3;
  assign thr_hit = (fq.count >= threshold);

  ////////////////////////////////////////////////////////////////////////////
  // Serial frame decode
  assign frame_start   = cs_fall | (cs_act & fs_rise);
  assign rise_in_frame = sclk_rise & cs_act;
  assign at_decode     = rise_in_frame & (bit_cnt_r == CMD_BITS - 5'h01);
  assign at_end        = rise_in_frame & (bit_cnt_r == FRAME_BITS - 5'h01);
  assign cmd_now       = {shift_in_r[2:0], sdi_in};
  assign word_now      = {shift_in_r[14:0], sdi_in};
  assign sel_end       = at_end & ~cmd_r[3];
  assign pop_now       = at_end & (cmd_r == CMD_RD_FIFO) & (fq.count != '0);

  // Bit counter wraps after 16 so frames can run back to back
  always_ff @(posedge sys_clk) begin
    if (!nrst || frame_start) begin
      bit_cnt_r <= '0;
    end else if (rise_in_frame) begin
      bit_cnt_r <= at_end ? 5'h00 : bit_cnt_r + 5'h01;
    end
  end

  // Input shift and command capture
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shift_in_r <= '0;
      cmd_r      <= CMD_SW_PD;
    end else begin
      if (rise_in_frame) shift_in_r <= word_now;
      if (at_decode) cmd_r <= cmd_now;
    end
  end

  // Configuration register survives every power-down
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      config_register_r <= CFG_RESET;
    end else if (at_end && cmd_r == CMD_WR_CFG) begin
      config_register_r <= word_now[11:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read-out path
  // Preload waits two cycles so the registered head reflects a pop
  assign next_rd  = (frame_start & after_int_r & fifo_mode)
                  | (at_end & (cmd_r == CMD_RD_FIFO) & frame_sync_in);
  assign load_now = load_dly_r[1];

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      load_dly_r <= '0;
    end else begin
      load_dly_r <= {load_dly_r[0], next_rd};
    end
  end

  // Output shifter; the fall after a frame's last rise is skipped so a reload keeps its MSB
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sdo_r       <= 1'b0;
      shift_out_r <= '0;
    end else if (load_now && fq.count != '0) begin
      sdo_r       <= fq.head_data[11];
      shift_out_r <= {fq.head_data[10:0], 5'h00};
    end else if (at_decode && cmd_now == CMD_RD_CFG && !fifo_mode) begin
      shift_out_r <= {config_register_r, 4'h0};
    end else if (sclk_fall && cs_act && bit_cnt_r != 5'h00) begin
      sdo_r       <= shift_out_r[15];
      shift_out_r <= {shift_out_r[14:0], 1'b0};
    end
  end

  // Output enable
  always_ff @(posedge sys_clk) begin
    if (!nrst || !cs_act) begin
      sdo_oe_r <= 1'b0;
    end else if (load_now && fq.count != '0) begin
      sdo_oe_r <= 1'b1;
    end else if (at_decode) begin
      if (cmd_now == CMD_RD_CFG) begin
        sdo_oe_r <= !fifo_mode;
      end else if (cmd_now != CMD_RD_FIFO) begin
        sdo_oe_r <= 1'b0;
      end
    end else if (at_end) begin
      sdo_oe_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt service tracking
  // After an interrupt in repeat sweep, any command other than a FIFO read drops the stale results
  assign clear_set = (at_decode & after_int_r & (mode == MODE_RPT_SWEEP)
                      & (cmd_now != CMD_RD_FIFO))
                   | (trig_fall & after_int_r & (mode == MODE_RPT_SWEEP))
                   | (sel_end & ~fifo_mode);
  assign fifo_clear = (clear_pend_r & buf_cnt_r != 2'h0) | pd_enter;

  // Set wins over clear for both flags
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      thr_hit_q_r  <= 1'b0;
      after_int_r  <= 1'b0;
      clear_pend_r <= 1'b0;
    end else begin
      thr_hit_q_r <= thr_hit;
      if (thr_hit && !thr_hit_q_r && fifo_mode) begin
        after_int_r <= 1'b1;
      end else if (at_decode || pd_enter) begin
        after_int_r <= 1'b0;
      end
      if (clear_set) begin
        clear_pend_r <= 1'b1;
      end else if (fifo_clear) begin
        clear_pend_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion clock
  assign div_last  = (clk_src == CLK_SCLK_DIV1) ? 2'h0 :
                     (clk_src == CLK_SCLK_DIV2) ? 2'h1 : 2'h3;
  assign conv_tick = (clk_src == CLK_INTERNAL) ? tb_rise
                   : (sclk_rise & (div_cnt_r == div_last));

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      div_cnt_r <= '0;
    end else if (sclk_rise) begin
      div_cnt_r <= (div_cnt_r == div_last) ? 2'h0 : div_cnt_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion triggers; reads and writes never raise one
  assign start_set = (sel_end & ~(~fifo_mode & ext_samp))
                   | (trig_fall & cs_n_in & fifo_mode & ref_int)
                   | ((state_r == CV_ARMED) & trig_rise);
  assign buf_room  = (buf_cnt_r != 2'h2);
  assign start_go  = (start_pend_r | start_set) & buf_room & ~pd_any
                   & (state_r != CV_RUN);
  assign conv_done = (state_r == CV_RUN) & conv_tick
                   & (tick_cnt_r == CONV_CLKS - 4'h1);
  assign start_chan = (mode == MODE_SWEEP || mode == MODE_RPT_SWEEP)
                    ? sweep_idx_r : (sel_end ? cmd_r[2:0] : sel_chan_r);
  assign sweep_last = (sweep_sel == 2'h0) ? 3'h1 :
                      (sweep_sel == 2'h1) ? 3'h3 : 3'h7;

  // A trigger that finds the buffer full waits here instead of being lost
  always_ff @(posedge sys_clk) begin
    if (!nrst || pd_enter) begin
      start_pend_r <= 1'b0;
    end else if (start_go) begin
      start_pend_r <= 1'b0;
    end else if (start_set) begin
      start_pend_r <= 1'b1;
    end
  end

  // Conversion sequencer
  always_ff @(posedge sys_clk) begin
    if (!nrst || pd_enter) begin
      state_r    <= CV_IDLE;
      tick_cnt_r <= '0;
    end else begin
      unique case (state_r)
        CV_IDLE: begin
          if (start_go) begin
            state_r <= CV_RUN;
          end else if (sel_end && !fifo_mode && ext_samp) begin
            state_r <= CV_ARMED;
          end
          tick_cnt_r <= '0;
        end
        CV_ARMED: begin
          if (start_go) state_r <= CV_RUN;
          tick_cnt_r <= '0;
        end
        CV_RUN: begin
          if (conv_done) begin
            state_r    <= CV_IDLE;
            tick_cnt_r <= '0;
          end else if (conv_tick) begin
            tick_cnt_r <= tick_cnt_r + 4'h1;
          end
        end
      endcase
    end
  end

  // Channel selection and sweep position
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sel_chan_r   <= '0;
      sweep_idx_r  <= '0;
      conv_chan_r  <= '0;
      conv_start_r <= 1'b0;
    end else begin
      conv_start_r <= start_go;
      if (sel_end) sel_chan_r <= cmd_r[2:0];
      if (start_go) conv_chan_r <= start_chan;
      if (pd_enter) begin
        sweep_idx_r <= '0;
      end else if (start_go && (mode == MODE_SWEEP || mode == MODE_RPT_SWEEP)) begin
        sweep_idx_r <= (sweep_idx_r >= sweep_last) ? 3'h0 : sweep_idx_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer between converter and FIFO
  assign buf_push = conv_done;
  assign buf_pop  = (buf_cnt_r != 2'h0) & ~clear_pend_r & ~pd_enter
                  & (fq.count != FIFO_CNT_W'(FIFO_DEPTH));
  assign buf_wsel = (buf_cnt_r == 2'h0) | ((buf_cnt_r == 2'h1) & buf_pop);

  always_ff @(posedge sys_clk) begin
    if (!nrst || pd_enter) begin
      buf_cnt_r <= '0;
    end else begin
      buf_cnt_r <= buf_cnt_r + {1'b0, buf_push} - {1'b0, buf_pop};
    end
  end

  // Data lanes; a push into the vacated slot overrides the shift
  always_ff @(posedge sys_clk) begin
    if (buf_pop) buf0_r <= buf1_r;
    if (buf_push && buf_wsel) buf0_r <= result_in;
    if (buf_push && !buf_wsel) buf1_r <= result_in;
  end

  // FIFO hookup
  assign fq.push      = buf_pop;
  assign fq.push_data = buf0_r;
  assign fq.pop       = pop_now;
  assign fq.clear     = fifo_clear;

  fifo_store #(.WIDTH(RES_W), .DEPTH(FIFO_DEPTH), .CNT_W(FIFO_CNT_W)) u_store (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .f       (fq)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared done / interrupt output, active low
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      eoc_cnt_r   <= '0;
      eoc_int_n_r <= 1'b1;
    end else begin
      if (conv_done && !fifo_mode && eoc_sel) begin
        eoc_cnt_r <= 6'(EOC_PULSE_CYC);
      end else if (eoc_cnt_r != '0) begin
        eoc_cnt_r <= eoc_cnt_r - 6'h01;
      end
      if (!fifo_mode && eoc_sel) begin
        eoc_int_n_r <= (eoc_cnt_r == '0);
      end else begin
        eoc_int_n_r <= ~thr_hit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power management
  assign pd_any   = sw_pd_r | ~pwdn_n_in;
  assign pd_enter = pd_any & ~pd_q_r;

  // Software power-down ends on the next select fall or trigger fall
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sw_pd_r   <= 1'b0;
      pd_q_r    <= 1'b0;
      auto_pd_r <= 1'b1;
    end else begin
      pd_q_r <= pd_any;
      if (at_end && cmd_r == CMD_SW_PD && word_now == SW_PD_WORD) begin
        sw_pd_r <= 1'b1;
      end else if (cs_fall || trig_fall) begin
        sw_pd_r <= 1'b0;
      end
      // One cycle to wake, far inside half a serial clock
      auto_pd_r <= ~(cs_act | ~sample_trigger_in_n | start_pend_r
                     | (state_r != CV_IDLE));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign sdo_out        = sdo_r;
  assign sdo_oe         = sdo_oe_r;
  assign eoc_int_n_out  = eoc_int_n_r;
  assign conv_start_out = conv_start_r;
  assign conv_chan_out  = conv_chan_r;
  assign auto_pd_out    = auto_pd_r;
  assign power_down_out = pd_q_r;
  assign config_out     = config_register_r;
endmodule

// ### bench/adc_seq_properties.sv
`timescale 1ns/10ps
// Port checks of the sequencer, using the hand-over latencies
module adc_seq_checker
  import adc_seq_pkg::*;
(
  input wire logic             sys_clk,
  input wire logic             nrst,
  input wire logic             cs_n_in,
  input wire logic             pwdn_n_in,
  input wire logic             sdo_oe,
  input wire logic             eoc_int_n_out,
  input wire logic             conv_start_out,
  input wire logic             auto_pd_out,
  input wire logic             power_down_out,
  input wire logic [RES_W-1:0] config_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  // Reset, start pulse, select-driven outputs and hardware power-down
  AST_RST: assert property ($rose(nrst) |-> !sdo_oe && eoc_int_n_out && config_out == CFG_RESET)
    else $error("reset state wrong");
  AST_START: assert property (conv_start_out |=> !conv_start_out)
    else $error("start pulse too long");
  AST_OE_CS: assert property (cs_n_in |=> !sdo_oe)
    else $error("sdo driven while deselected");
  AST_CFG: assert property (cs_n_in && $past(cs_n_in) |-> $stable(config_out))
    else $error("config changed without access");
  AST_HWPD: assert property (!pwdn_n_in |=> power_down_out)
    else $error("power-down not entered");
  AST_WAKE: assert property (!cs_n_in && pwdn_n_in |-> ##[1:3] !auto_pd_out)
    else $error("no wake on select");
  // Level interrupt in FIFO modes, fixed pulse in mode 00 with bit 7 set
  AST_INT: assert property ($fell(eoc_int_n_out) && config_out[6:5] != 2'h0 && pwdn_n_in
    |=> !eoc_int_n_out [*8])
    else $error("interrupt not held");
  AST_EOC: assert property ($fell(eoc_int_n_out) && config_out[7] && config_out[6:5] == 2'h0
    |=> !eoc_int_n_out [*8] ##17 eoc_int_n_out)
    else $error("done pulse width wrong");
endmodule
bind adc_serial_fifo_sequencer adc_seq_checker chk_u (.sys_clk(sys_clk), .nrst(nrst),
  .cs_n_in(cs_n_in), .pwdn_n_in(pwdn_n_in), .sdo_oe(sdo_oe), .eoc_int_n_out(eoc_int_n_out),
  .conv_start_out(conv_start_out), .auto_pd_out(auto_pd_out),
  .power_down_out(power_down_out), .config_out(config_out));

// ### bench/host_port.sv
`timescale 1ns/10ps
// Host serial port; clock idles low and runs only inside a select window
module host_port (
  input  wire logic sys_clk,
  input  wire logic sdo_out,
  input  wire logic sdo_oe,
  output logic      sclk_in,
  output logic      cs_n_in,
  output logic      frame_sync_in,
  output logic      sdi_in
);
  initial begin
    sclk_in = 1'b0;
    cs_n_in = 1'b1;
    frame_sync_in = 1'b1;
    sdi_in = 1'b0;
  end
  // n words in one select, 8-cycle clock so a divided rate stays low
  task automatic xfer(input logic [15:0] w, input int n, output logic [63:0] rd,
                      output logic oe_any);
    int i;
    rd = '0;
    oe_any = 1'b0;
    @(negedge sys_clk) cs_n_in = 1'b0; // Held for 16 clocks or more
    for (i = 0; i < 16 * n; i++) begin
      sdi_in = w[15 - i % 16];
      repeat (4) @(negedge sys_clk);
      rd = {rd[62:0], sdo_out};
      oe_any = oe_any | sdo_oe;
      sclk_in = 1'b1;
      repeat (4) @(negedge sys_clk);
      sclk_in = 1'b0;
      if (i % 16 == 15) repeat (10) @(negedge sys_clk); // Clock halts between frames
    end
    cs_n_in = 1'b1;
    sdi_in = ~sdi_in; // Released line must not look held
  endtask
endmodule

// ### bench/testbench.sv
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin fail_count++; \
  $display("mismatch %s exp %0h got %0h", nm, e, a); end end
module testbench;
  import adc_seq_pkg::*;
  logic             sys_clk = 1'b0;
  logic             nrst = 1'b0;
  logic             pwdn_n = 1'b1;
  logic             trig_n = 1'b1;
  logic             tbase = 1'b0;
  logic [RES_W-1:0] result = '0;
  logic [RES_W-1:0] c0, c1, cfg;
  logic [RES_W-1:0] res_q [4];
  logic [63:0]      rd;
  logic             oe_any, sclk, cs_n, fs, sdi, sdo, oe, eoc_n, sample_trigger_in, apd, pd;
  logic [2:0]       chan, last_ch;
  int               seed = 4;
  int               checked = 0;
  int               fail_count = 0;
  int               starts = 0;
  int               n, i;
  always #2 sys_clk = ~sys_clk;
  always #4 tbase = ~tbase; // Conversion ticks every 2 cycles
  always @(posedge sys_clk) if (sample_trigger_in === 1'b1) begin
    starts <= starts + 1;
    last_ch <= chan;
  end
  host_port host_u (.sys_clk(sys_clk), .sdo_out(sdo), .sdo_oe(oe), .sclk_in(sclk),
    .cs_n_in(cs_n), .frame_sync_in(fs), .sdi_in(sdi));
  adc_serial_fifo_sequencer dut_u (.sys_clk(sys_clk), .nrst(nrst), .sclk_in(sclk),
    .cs_n_in(cs_n), .frame_sync_in(fs), .sdi_in(sdi), .sample_trigger_in_n(trig_n),
    .pwdn_n_in(pwdn_n), .onchip_timebase(tbase), .result_in(result), .sdo_out(sdo),
    .sdo_oe(oe), .eoc_int_n_out(eoc_n), .conv_start_out(sample_trigger_in), .conv_chan_out(chan),
    .auto_pd_out(apd), .power_down_out(pd), .config_out(cfg));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] fifo_word(input logic [11:0] v);
    return {v, 4'h0};
  endfunction
  function automatic int depth_of(input logic [11:0] c);
    return c[6:5] == 2'h0 ? 1 : 8 - 2 * c[1:0];
  endfunction
  task automatic close_out;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic wait_eoc(input logic lvl);
    int k;
    for (k = 0; k < 500 && eoc_n !== lvl; k++) @(negedge sys_clk);
    `CHK("eoc wait", lvl, eoc_n)
    if (eoc_n !== lvl) close_out();
  endtask
  // Select frame on a random channel, result held for the conversion
  task automatic convert(input logic [11:0] v);
    logic [2:0] ch;
    ch = 3'($random(seed));
    result = v;
    host_u.xfer({1'b0, ch, 12'h000}, 1, rd, oe_any);
    `CHK("chan", ch, last_ch)
  endtask
  task automatic fill(input int cnt);
    for (i = 0; i < cnt; i++) begin
      res_q[i] = 12'($random(seed));
      convert(res_q[i]);
      repeat (40) @(negedge sys_clk); // 14 ticks plus buffering
      if (i < cnt - 1) `CHK("int early", 1'b1, eoc_n)
    end
    wait_eoc(1'b0);
    repeat (10) @(negedge sys_clk);
  endtask
  task automatic pulse_pd;
    pwdn_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    pwdn_n = 1'b1;
    repeat (3) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge sys_clk);
    nrst = 1'b1;
    // Single shot with done pulse; depth bits random and ignored
    c0 = (12'($random(seed)) & 12'hB03) | 12'h080;
    host_u.xfer({CMD_WR_CFG, c0}, 1, rd, oe_any);
    `CHK("cfg", c0, cfg)
    convert(12'($random(seed)));
    wait_eoc(1'b0);
    host_u.xfer({CMD_RD_CFG, 12'h000}, 1, rd, oe_any);
    `CHK("rd cfg", c0, rd[11:0])
    pulse_pd();
    `CHK("cfg kept", c0, cfg)
    // Repeat mode: read-back refused, then threshold and ordered FIFO read
    c1 = (12'($random(seed)) & 12'h801) | 12'h022;
    host_u.xfer({CMD_WR_CFG, c1}, 1, rd, oe_any);
    host_u.xfer({CMD_RD_CFG, 12'h000}, 1, rd, oe_any);
    `CHK("rd cfg oe", 1'b0, oe_any)
    `CHK("starts", 1, starts)
    n = depth_of(c1);
    fill(n);
    host_u.xfer({CMD_RD_FIFO, 12'h000}, n, rd, oe_any);
    for (i = 0; i < n; i++) `CHK("fifo", fifo_word(res_q[i]), rd[16*(n-i)-1 -: 16])
    `CHK("int served", 1'b1, eoc_n)
    `CHK("starts", 1 + n, starts)
    fill(n);
    pulse_pd();
    `CHK("fifo cleared", 1'b1, eoc_n)
    `CHK("cfg kept", c1, cfg)
    // Trigger with select high starts only on internal reference
    trig_n = 1'b0; // No select cycle open, no conversion to cancel
    repeat (4) @(negedge sys_clk);
    trig_n = 1'b1;
    repeat (40) @(negedge sys_clk);
    `CHK("trig start", 1 + 2 * n + c1[11], starts)
    close_out();
  end
endmodule
